// ### src/cer_device.sv
`timescale 1ns/1ns
`default_nettype none
module cer_device
  import cer_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [CER_SIG_W-1:0] PRECOMP_I,
  input wire logic [CER_SIG_W-1:0] CALC_SIG_I,
  input wire logic CALC_DONE_I,
  input wire logic RECONFIG_REQUEST_N_I,
  cer_if.dev port
);
  // CLK_I stands in for the configuration oscillator. The signature, the
  // reference copy and the error flag all run on it; only the readout shift
  // register runs on the user's readout clock, so a stopped readout clock
  // can never hide an error.
  // RST_I clears only oscillator-side state; the readout port has no reset.

  typedef enum logic [1:0] {
    CFG_RUN = 2'h1,
    CFG_RELOAD = 2'h2
  } cer_cfg_t;

  // Reconfiguration request comes from the surrounding system, a pin
  logic rq_meta;
  logic next_rq_meta;
  logic rq_sync;
  logic next_rq_sync;
  cer_cfg_t cfg_st;
  cer_cfg_t next_cfg_st;
  logic reload;

  // Oscillator-side state
  logic [CER_SIG_W-1:0] ref_reg;
  logic [CER_SIG_W-1:0] next_ref_reg;
  logic [CER_SIG_W-1:0] sig_reg;
  logic [CER_SIG_W-1:0] next_sig_reg;
  logic sig_mismatch;
  logic err;
  logic next_err;

  // Readout-side state
  logic [CER_SIG_W-1:0] load_word;
  logic [CER_SIG_W-1:0] shift_word;
  logic [CER_SIG_W-1:0] shreg;
  logic [CER_SIG_W-1:0] next_shreg;

  // Two flip-flops before the request is used; only the second reads the first.
  always_comb begin
    next_rq_meta = RECONFIG_REQUEST_N_I;
    next_rq_sync = rq_meta;
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rq_meta <= 1'b1;
      rq_sync <= 1'b1;
    end else begin
      rq_meta <= next_rq_meta;
      rq_sync <= next_rq_sync;
    end
  end

  // A request rewrites the configuration. The rewrite lasts while the request
  // is held low and one cycle after its release, and clears signature and flag.
  always_comb begin
    next_cfg_st = cfg_st;
    unique case (cfg_st)
      CFG_RUN: begin
        if (!rq_sync) begin
          next_cfg_st = CFG_RELOAD;
        end
      end
      CFG_RELOAD: begin
        if (rq_sync) begin
          next_cfg_st = CFG_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      cfg_st <= CFG_RUN;
    end else begin
      cfg_st <= next_cfg_st;
    end
  end

  assign reload = !rq_sync || (cfg_st == CFG_RELOAD);

  // The stored reference follows the configured value; it is what a
  // load from the pre-computed source hands out.
  always_comb begin
    next_ref_reg = PRECOMP_I;
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ref_reg <= CER_PRECOMP_RST;
    end else begin
      ref_reg <= next_ref_reg;
    end
  end

  // Signature register; a fresh result wins over a clear by reconfiguration.
  always_comb begin
    next_sig_reg = sig_reg;
    if (reload) begin
      next_sig_reg = CER_SIG_RST;
    end
    if (CALC_DONE_I) begin
      next_sig_reg = CALC_SIG_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sig_reg <= CER_SIG_RST;
    end else begin
      sig_reg <= next_sig_reg;
    end
  end

  // The comparison uses the live reference so a result and a new
  // reference offered in the same cycle are judged together.
  assign sig_mismatch = CALC_DONE_I && (CALC_SIG_I != PRECOMP_I);

  // Error flag: sticky until reconfiguration. A mismatch in the same cycle as
  // a clear wins, so an error met during the rewrite is not lost.
  always_comb begin
    next_err = err;
    if (reload) begin
      next_err = 1'b0;
    end
    if (sig_mismatch) begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      err <= 1'b0;
    end else begin
      err <= next_err;
    end
  end

  assign port.err_flag = err;

  // Readout side. The shift register has no reset: the serial output is
  // undefined until the first load. The reference and signature are
  // read on the readout clock without a synchroniser; that clock is derived
  // from CLK_I and both words are settled long before a readout starts.
  always_comb begin
    if (port.load_src) begin
      load_word = sig_reg;
    end else begin
      load_word = ref_reg;
    end
  end

  // Each bit takes its upper neighbour; the top bit fills with zero.
  for (genvar b = 0; b < CER_SIG_W; b++) begin : g_shift
    if (b == CER_SIG_W - 1) begin : g_top
      assign shift_word[b] = 1'b0;
    end else begin : g_mid
      assign shift_word[b] = shreg[b + 1];
    end
  end

  // The select is read only on the load branch.
  always_comb begin
    if (port.shift_nload) begin
      next_shreg = shift_word;
    end else begin
      next_shreg = load_word;
    end
  end

  // The user changes shift_nload and load_src only while the readout clock is low or
  // falling, so the rising edge here never races them. A user who changes
  // them on the rising edge gets an undefined load.
  always_ff @(posedge port.rd_clk) begin
    shreg <= next_shreg;
  end

  // Bit zero leaves first, so the word comes out least significant bit first.
  assign port.ser_out = shreg[0];
endmodule : cer_device
`default_nettype wire

// ### src/cer_pkg.sv
package cer_pkg;
  localparam int CER_SIG_W = 32;
  localparam int CER_LOAD_MIN_CYC = 2;
  localparam int CER_READ_EXTRA_CYC = 31;
  localparam logic [31:0] CER_PRECOMP_RST = 32'h0000_0000;
  localparam logic [31:0] CER_SIG_RST = 32'h0000_0000;
  localparam logic [5:0] CER_BIT_CNT_RST = 6'h00;
endpackage : cer_pkg

// ### src/cer_if.sv
`timescale 1ns/1ns
`default_nettype none
// Readout port between the error detection circuit and user core logic
interface cer_if;
  logic rd_clk;
  logic shift_nload;
  logic load_src;
  logic ser_out;
  logic err_flag;
  modport dev (input rd_clk, input shift_nload, input load_src, output ser_out, output err_flag);
  modport usr (output rd_clk, output shift_nload, output load_src, input ser_out, input err_flag);
endinterface : cer_if
`default_nettype wire

// ### src/cer_user.sv
`timescale 1ns/1ns
`default_nettype none
module cer_user
  import cer_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic START_I,
  input wire logic LOAD_SRC_I,
  output logic BUSY_O,
  output logic DONE_O,
  output logic [CER_SIG_W-1:0] WORD_O,
  output logic ERROR_O,
  output logic RECONFIG_REQUEST_N_O,
  cer_if.usr port
);
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_LOAD = 4'h2,
    S_SHIFT = 4'h4,
    S_DONE = 4'h8
  } cer_state_t;

  cer_state_t st, next_st;
  logic phase, next_phase;
  logic [5:0] cnt, next_cnt;
  logic [CER_SIG_W-1:0] word, next_word;
  logic snl, next_snl;
  logic src, next_src;
  logic e1, e2, err, next_err;
  logic rq_n, next_rq_n;
  logic busy, next_busy;
  logic done, next_done;

  // Readout clock is CLK_I divided by two and runs only during a readout,
  // so the device's shift register stands still between readouts.
  always_comb begin
    next_st = st;
    next_phase = phase;
    next_cnt = cnt;
    next_word = word;
    next_snl = snl;
    next_src = src;
    next_err = e2;
    next_rq_n = ~(e2 & ~err);
    unique case (st)
      S_IDLE: begin
        if (START_I) begin
          next_st = S_LOAD;
          next_snl = 1'b0;
          next_src = LOAD_SRC_I;
          next_cnt = CER_BIT_CNT_RST;
        end
      end
      S_LOAD: begin
        next_phase = ~phase;
        if (phase) begin
          next_cnt = cnt + 6'h01;
          if (cnt == 6'(CER_LOAD_MIN_CYC - 1)) begin
            next_st = S_SHIFT;
            next_snl = 1'b1;
            next_cnt = CER_BIT_CNT_RST;
          end
        end
      end
      S_SHIFT: begin
        next_phase = ~phase;
        if (!phase) begin
          next_word = {port.ser_out, word[CER_SIG_W-1:1]};
          next_cnt = cnt + 6'h01;
          // Last sample taken: no further rise, so exactly 31 shifts follow a load
          if (cnt == 6'(CER_READ_EXTRA_CYC)) begin
            next_st = S_DONE;
            next_phase = 1'b0;
          end
        end
      end
      S_DONE: next_st = S_IDLE;
    endcase
    next_busy = (next_st != S_IDLE);
    next_done = (next_st == S_DONE);
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st <= S_IDLE;
      phase <= 1'b0;
      cnt <= CER_BIT_CNT_RST;
      word <= CER_SIG_RST;
      snl <= 1'b1;
      src <= 1'b0;
      e1 <= 1'b0;
      e2 <= 1'b0;
      err <= 1'b0;
      rq_n <= 1'b1;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      st <= next_st;
      phase <= next_phase;
      cnt <= next_cnt;
      word <= next_word;
      snl <= next_snl;
      src <= next_src;
      e1 <= port.err_flag;
      e2 <= e1;
      err <= next_err;
      rq_n <= next_rq_n;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign port.rd_clk = phase;
  assign port.shift_nload = snl;
  assign port.load_src = src;
  assign BUSY_O = busy;
  assign DONE_O = done;
  assign WORD_O = word;
  assign ERROR_O = err;
  assign RECONFIG_REQUEST_N_O = rq_n;
endmodule : cer_user
`default_nettype wire

// ### testbench/cer_checker.sv
`timescale 1ns/1ns
`default_nettype none
module cer_checker (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic rd_clk,
  input wire logic shift_nload,
  input wire logic load_src,
  input wire logic ser_out,
  input wire logic err_flag
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  a_ser_rise: assert property ($changed(ser_out) |-> $rose(rd_clk)) else $error("ser");
  a_ser_fall: assert property ($fell(rd_clk) |-> $stable(ser_out)) else $error("ser");
  a_load_low: assert property ($fell(shift_nload) |-> !shift_nload[*3]) else $error("load");
  a_load_clk: assert property ($fell(shift_nload) |-> ##[1:3] $rose(rd_clk)) else $error("load");
  a_read_len: assert property ($rose(shift_nload) |-> shift_nload[*8]) else $error("read");
  a_shift_clk: assert property ($rose(shift_nload) |-> ##[0:3] $rose(rd_clk)) else $error("shift");
  a_flag_hold: assert property ($rose(err_flag) |=> err_flag[*2]) else $error("flag");
  a_src_hold: assert property ($fell(shift_nload) |=> $stable(load_src)) else $error("src");
endmodule : cer_checker
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 1'b0, rst = 1'b1, dn = 1'b0, go = 1'b0, src = 1'b0, fin, rq, busy, err;
  logic [31:0] pre = 32'h0, sig = 32'h0, wd, mdl_sig;
  logic [31:0] exp_q[$];
  int mismatches, checks, k;
  bit hung;
  cer_if f ();
  cer_device cer_device_i (.CLK_I(clk), .RST_I(rst), .PRECOMP_I(pre), .CALC_SIG_I(sig), .CALC_DONE_I(dn),
    .RECONFIG_REQUEST_N_I(rq), .port(f.dev));
  cer_user cer_user_i (.CLK_I(clk), .RST_I(rst), .START_I(go), .LOAD_SRC_I(src), .BUSY_O(busy), .DONE_O(fin),
    .WORD_O(wd), .ERROR_O(err), .RECONFIG_REQUEST_N_O(rq), .port(f.usr));
  cer_checker cer_checker_i (.CLK_I(clk), .RST_I(rst), .rd_clk(f.rd_clk), .shift_nload(f.shift_nload),
    .load_src(f.load_src), .ser_out(f.ser_out), .err_flag(f.err_flag));
  initial forever #5 clk = ~clk;
  task automatic cmp_word(input string n, input logic [31:0] e, s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : cmp_word
  task automatic cmp_flag(input string n, input logic e, s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s exp %b got %b", n, e, s);
    end
  endtask : cmp_flag
  task automatic end_of_test();
    $display("%0d/%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  initial begin
    k = $urandom(32'h105F41A6);
    hung = 1'b0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 6 && !hung; i++) begin
      pre = $urandom;
      sig = i < 2 ? pre : $urandom;
      src = i[0];
      // Model: recovery clears the signature, so a failed run reads back zero
      mdl_sig = (sig != pre) ? 32'h0 : sig;
      exp_q.push_back(src ? mdl_sig : pre);
      dn = 1'b1;
      @(negedge clk);
      dn = 1'b0;
      for (k = 0; k < 20 && rq !== 1'b0; k++) @(negedge clk);
      cmp_flag("rcfg", sig != pre, k < 20);
      cmp_flag("error", sig != pre, err);
      go = 1'b1;
      for (k = 0; k < 200 && fin !== 1'b1; k++) @(negedge clk);
      go = 1'b0;
      if (k == 200) begin
        mismatches++;
        hung = 1'b1;
      end else begin
        cmp_flag("busy", 1'b1, busy);
        cmp_word("word", exp_q.pop_front(), wd);
        @(negedge clk);
        cmp_flag("idle", 1'b0, busy);
      end
      $display("test %0d", i);
    end
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
